// ### verilog/zcd_top.sv
`timescale 1ns/1ps
module zcd_top (
	// System
	input wire logic CLK_SYS,
	input wire logic RST,
	// Configuration strap and power state
	input wire logic POR_DISABLE,
	input wire logic SLEEP,
	// Analog comparator and pin
	input wire logic COMP_SINKING,
	output logic ANALOG_DRIVE_EN,
	output logic PIN_DIGITAL_SEL,
	// Logic cell feed and interrupt
	output logic CROSSING_LEVEL,
	output logic IRQ,
	// AXI4-Lite write address
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	import zcd_pkg::*;

	// ***************************************************
	// Declarations
	// ***************************************************
	logic [7:0] control_r;
	logic event_flag_r;
	logic irq_enable_r;
	logic por_dis_s1_r;
	logic por_dis_r;
	logic por_dis_s2_r;
	logic [1:0] strap_count_r;
	logic sink_sync;
	logic level;
	logic rise;
	logic fall;
	logic active;
	logic [3:0] aw_addr_r;
	logic aw_held_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_held_r;
	logic wr_fire;
	logic wr_low_lane;
	logic [7:0] wr_byte;
	logic flag_clear;
	logic sleep_s1_r;
	logic sleep_r;
	logic wr_control;
	logic wr_irq_flag;
	logic wr_irq_enable;
	logic [31:0] rd_word;

	// Register address decode, used for read and write
	function automatic logic addr_known(input logic [3:0] a);
		addr_known = (a == OFS_CONTROL) || (a == OFS_IRQ_FLAG) ||
			(a == OFS_IRQ_ENABLE) || (a == OFS_STATUS);
	endfunction : addr_known

	// Write strobe for one register: fired, low lane enabled, address matches
	// Shared by every writable register so all of them honour the byte strobe alike
	function automatic logic write_hit(input logic fire, input logic lane, input logic [3:0] addr,
		input logic [3:0] target);
		write_hit = fire && lane && (addr == target);
	endfunction : write_hit

	// ***************************************************
	// Strap capture
	// ***************************************************
	// Strap is a pin: two flops, then latch once a few edges after release
	// Latching waits until the second stage holds the pin and not its reset value
	// Later strap changes are ignored until the next reset
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			por_dis_s1_r <= RESET_BIT;
			por_dis_s2_r <= RESET_BIT;
			por_dis_r <= RESET_BIT;
			strap_count_r <= 2'h0;
		end else begin
			por_dis_s1_r <= POR_DISABLE;
			por_dis_s2_r <= por_dis_s1_r;
			if (strap_count_r != STRAP_CAPTURE_COUNT) begin
				strap_count_r <= strap_count_r + 2'h1;
				por_dis_r <= por_dis_s2_r;
			end
		end
	end

	// Sleep is only reported, it never gates the detector
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sleep_s1_r <= RESET_BIT;
			sleep_r <= RESET_BIT;
		end else begin
			sleep_s1_r <= SLEEP;
			sleep_r <= sleep_s1_r;
		end
	end

	// Strap clear: always on; strap set: enable bit decides
	// Strap not yet taken counts as clear, so detector runs from reset
	assign active = !por_dis_r || control_r[BIT_ENABLE];

	// ***************************************************
	// Comparator path
	// ***************************************************
	zcd_sync u_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.d(COMP_SINKING),
		.q(sink_sync)
	);

	// Polarity applied after sync so an invert write is an edge too
	assign level = sink_sync ^ control_r[BIT_INVERT];

	zcd_edge u_edge (
		.clk(CLK_SYS),
		.rst(RST),
		.level(level),
		.rise(rise),
		.fall(fall)
	);

	// ***************************************************
	// Pin and logic-cell outputs
	// ***************************************************
	// Analog drive owns the pin while the detector runs
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ANALOG_DRIVE_EN <= RESET_BIT;
		end else begin
			ANALOG_DRIVE_EN <= active;
		end
	end

	// Ordinary routing gets the pin back when the detector stops
	// Same source as the drive enable, so the two never overlap in a cycle
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			PIN_DIGITAL_SEL <= PIN_SEL_RESET;
		end else begin
			PIN_DIGITAL_SEL <= !active;
		end
	end

	// Level to the logic cells, registered so the cells see no decode glitch
	// Runs even with the detector off, as the invert bit still makes edges
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			CROSSING_LEVEL <= RESET_BIT;
		end else begin
			CROSSING_LEVEL <= level;
		end
	end

	// ***************************************************
	// AXI4-Lite write channel
	// ***************************************************
	assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID;
	assign wr_low_lane = w_strb_r[0];
	assign wr_byte = w_data_r[7:0];
	assign wr_control = write_hit(wr_fire, wr_low_lane, aw_addr_r, OFS_CONTROL);
	assign wr_irq_flag = write_hit(wr_fire, wr_low_lane, aw_addr_r, OFS_IRQ_FLAG);
	assign wr_irq_enable = write_hit(wr_fire, wr_low_lane, aw_addr_r, OFS_IRQ_ENABLE);
	// Writing a zero leaves the flag alone
	assign flag_clear = wr_irq_flag && wr_byte[BIT_EVENT];

	// Address and data accepted independently, held until the write fires
	// Ready pulses while idle, so a waiting master is taken within two edges
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			aw_held_r <= RESET_BIT;
			aw_addr_r <= 4'h0;
			S_AXI_AWREADY <= RESET_BIT;
		end else begin
			S_AXI_AWREADY <= !aw_held_r && !S_AXI_AWREADY;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			w_held_r <= RESET_BIT;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			S_AXI_WREADY <= RESET_BIT;
		end else begin
			S_AXI_WREADY <= !w_held_r && !S_AXI_WREADY;
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			S_AXI_BVALID <= RESET_BIT;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= addr_known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// ***************************************************
	// Control and enable registers
	// ***************************************************
	// Unimplemented and read-only bits never store a value
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			control_r <= CONTROL_RESET;
		end else if (wr_control) begin
			control_r <= wr_byte & CONTROL_WR_MASK;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			irq_enable_r <= RESET_BIT;
		end else if (wr_irq_enable) begin
			irq_enable_r <= wr_byte[BIT_EVENT];
		end
	end

	// ***************************************************
	// Event flag and interrupt
	// ***************************************************
	// Set beats clear so an edge during the clear is kept
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			event_flag_r <= RESET_BIT;
		end else if ((rise && control_r[BIT_RISE_EN]) || (fall && control_r[BIT_FALL_EN])) begin
			event_flag_r <= 1'b1;
		end else if (flag_clear) begin
			event_flag_r <= 1'b0;
		end
	end

	// Upstream global enables live outside this block
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			IRQ <= RESET_BIT;
		end else begin
			IRQ <= event_flag_r && irq_enable_r;
		end
	end

	// ***************************************************
	// Read data select
	// ***************************************************
	// Word chosen from the offered address; unmapped offsets read zero
	// Read-only bits come from live state, never from a stored copy
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (S_AXI_ARADDR)
			OFS_CONTROL: begin
				rd_word[7:0] = control_r;
				rd_word[BIT_LEVEL] = level;
			end
			OFS_IRQ_FLAG: rd_word[BIT_EVENT] = event_flag_r;
			OFS_IRQ_ENABLE: rd_word[BIT_EVENT] = irq_enable_r;
			OFS_STATUS: begin
				rd_word[BIT_STAT_ACTIVE] = active;
				rd_word[BIT_STAT_RAW] = sink_sync;
				rd_word[BIT_STAT_POR_DIS] = por_dis_r;
				rd_word[BIT_STAT_SLEEP] = sleep_r;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ***************************************************
	// AXI4-Lite read channel
	// ***************************************************
	// Ready drops while an answer is pending, so one read at a time
	// Data is captured at the address handshake and held until taken
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			S_AXI_ARREADY <= RESET_BIT;
			S_AXI_RVALID <= RESET_BIT;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= addr_known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
				S_AXI_RDATA <= rd_word;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule : zcd_top

// ### verilog/zcd_pkg.sv
package zcd_pkg;

	// ***************************************************
	// Register map (byte addresses, one word each)
	// ***************************************************
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_IRQ_FLAG = 4'h4;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// ***************************************************
	// Control register fields
	// ***************************************************
	localparam int BIT_ENABLE = 7;
	localparam int BIT_LEVEL = 5;
	localparam int BIT_INVERT = 4;
	localparam int BIT_RISE_EN = 1;
	localparam int BIT_FALL_EN = 0;
	// Only these bits hold state; bit 5 reads the live level, the rest read zero
	localparam logic [7:0] CONTROL_WR_MASK = 8'h93;

	// ***************************************************
	// Flag, enable and status register fields
	// ***************************************************
	localparam int BIT_EVENT = 4;
	localparam int BIT_STAT_ACTIVE = 0;
	localparam int BIT_STAT_RAW = 1;
	localparam int BIT_STAT_POR_DIS = 2;
	localparam int BIT_STAT_SLEEP = 3;

	// ***************************************************
	// Reset values and bus answers
	// ***************************************************
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic RESET_BIT = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int SYNC_STAGES = 2;
	// Edges after release at which the synchronised strap is latched
	localparam logic [1:0] STRAP_CAPTURE_COUNT = 2'h3;
	// Pin starts on ordinary routing
	localparam logic PIN_SEL_RESET = 1'b1;

endpackage : zcd_pkg

// ### verilog/zcd_sync.sv
`timescale 1ns/1ps
// Two-stage level synchroniser; first stage feeds only the second
module zcd_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level
	input wire logic d,
	output logic q
);
	import zcd_pkg::*;

	logic meta_r;

	// Metastability guard chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= RESET_BIT;
			q <= RESET_BIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule : zcd_sync

// ### verilog/zcd_edge.sv
`timescale 1ns/1ps
// Rising and falling edge detectors on the logic level
module zcd_edge (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in, one-cycle pulses out
	input wire logic level,
	output logic rise,
	output logic fall
);
	import zcd_pkg::*;

	logic prev_r;

	// Previous level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_r <= RESET_BIT;
		end else begin
			prev_r <= level;
		end
	end

	// Edges compare against last cycle
	assign rise = level & ~prev_r;
	assign fall = ~level & prev_r;

endmodule : zcd_edge

// ### test/zcd_checker.sv
`timescale 1ns/1ps
module zcd_checker (
	// Clock, reset and strap
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic POR_DISABLE,
	// Pin side
	input wire logic COMP_SINKING,
	input wire logic ANALOG_DRIVE_EN,
	input wire logic PIN_DIGITAL_SEL,
	input wire logic CROSSING_LEVEL,
	// Bus handshakes
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	// ****
	// Pin ownership, power-on state and crossing level
	// ****
	chk_pin_owner: assert property (
		PIN_DIGITAL_SEL == !ANALOG_DRIVE_EN) else $error("pin owner mismatch");
	chk_por_active: assert property (
		$fell(RST) && !POR_DISABLE |=> ANALOG_DRIVE_EN) else $error("not active after reset");
	// Strap clear wins over whatever software writes
	chk_strap_clear_on: assert property (
		(!POR_DISABLE) [*4] |=> ANALOG_DRIVE_EN) else $error("drive dropped");
	// Level moves only from the comparator or a register write
	chk_level_quiet: assert property (
		(!S_AXI_AWVALID && !S_AXI_BVALID && $stable(COMP_SINKING)) [*8] |-> $stable(CROSSING_LEVEL))
		else $error("level moved alone");
	// ****
	// Register bus answers
	// ****
	chk_read_answer: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read late");
	chk_write_answer: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
		else $error("write late");
	chk_b_single: assert property (
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("extra write answer");
	chk_r_single: assert property (
		S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("extra read answer");
endmodule : zcd_checker

bind zcd_top zcd_checker i_zcd_checker (.CLK_SYS(CLK_SYS), .RST(RST), .POR_DISABLE(POR_DISABLE),
	.COMP_SINKING(COMP_SINKING), .ANALOG_DRIVE_EN(ANALOG_DRIVE_EN), .PIN_DIGITAL_SEL(PIN_DIGITAL_SEL),
	.CROSSING_LEVEL(CROSSING_LEVEL), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ### test/zcd_ac_model.sv
`timescale 1ns/1ps
// Comparator seen through the series resistor; changes with no regard to the clock
module zcd_ac_model (
	// Wanted waveform side
	input wire logic sink_cmd,
	// Comparator result, high while sinking
	output logic comp_sinking
);
	initial comp_sinking = 1'b0;
	// Odd delay keeps changes away from clock edges
	always @(sink_cmd) comp_sinking <= #3 sink_cmd;
endmodule : zcd_ac_model

// ### test/zcd_top_tb_top.sv
`timescale 1ns/1ps
module zcd_top_tb_top;
	import zcd_pkg::*;
	logic clk;
	logic rst = 1'b1;
	logic por_dis = 1'b0;
	logic sleep = 1'b0;
	logic sink_cmd = 1'b0;
	logic aw_v = 1'b0;
	logic w_v = 1'b0;
	logic b_r = 1'b0;
	logic ar_v = 1'b0;
	logic r_r = 1'b0;
	logic [3:0] aw_a = 4'h0;
	logic [3:0] ar_a = 4'h0;
	logic [31:0] w_d = 32'h0;
	logic [3:0] w_s = 4'hF;
	logic comp, drive, dsel, lvl, irq, aw_r, w_r, b_v, ar_r, r_v;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_d;
	logic [31:0] rdat;
	logic [1:0] rrsp;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;

	zcd_ac_model i_zcd_ac_model (.sink_cmd(sink_cmd), .comp_sinking(comp));
	zcd_top i_zcd_top (.CLK_SYS(clk), .RST(rst), .POR_DISABLE(por_dis), .SLEEP(sleep), .COMP_SINKING(comp),
		.ANALOG_DRIVE_EN(drive), .PIN_DIGITAL_SEL(dsel), .CROSSING_LEVEL(lvl), .IRQ(irq),
		.S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(w_d),
		.S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r), .S_AXI_BRESP(b_resp),
		.S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v),
		.S_AXI_ARREADY(ar_r), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r));

	// 125 MHz system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****
	// Shared tasks
	// ****
	task automatic final_report();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		aw_a <= a;
		w_d <= {24'h0, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (aw_v && aw_r) begin
				aw_done = 1'b1;
				aw_v <= 1'b0;
			end
			if (w_v && w_r) begin
				w_done = 1'b1;
				w_v <= 1'b0;
			end
		end
		do @(posedge clk); while (!b_v);
		b_r <= 1'b0;
		chk(b_resp, er);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do @(posedge clk); while (!ar_r);
		ar_v <= 1'b0;
		do @(posedge clk); while (!r_v);
		r_r <= 1'b0;
		rdat = r_d;
		rrsp = r_resp;
	endtask : rd

	task automatic rc(input logic [3:0] a, input logic [7:0] exp);
		rd(a);
		chk(rrsp, RESP_OKAY);
		chk(rdat, {24'h0, exp});
	endtask : rc

	task automatic do_reset();
		rst <= 1'b1;
		idle(16);
		rst <= 1'b0;
		idle(6);
	endtask : do_reset

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	// ****
	// Test sequence
	// ****
	initial begin
		do_reset();
		chk(drive, 1);
		chk(dsel, 0);
		rc(OFS_CONTROL, 8'h00);
		rc(OFS_IRQ_FLAG, 8'h00);
		rc(OFS_IRQ_ENABLE, 8'h00);
		rc(OFS_STATUS, 8'h01);
		wr(OFS_CONTROL, 8'hFF, RESP_OKAY);
		rc(OFS_CONTROL, (8'hFF & CONTROL_WR_MASK) | 8'h20);
		wr(OFS_CONTROL, 8'h00, RESP_OKAY);
		idle(4);
		chk(drive, 1);
		rd(4'h2);
		chk(rrsp, RESP_SLVERR);
		wr(4'h2, 8'hFF, RESP_SLVERR);
		// Low lane strobe off: the write is answered but ignored
		w_s <= 4'h0;
		wr(OFS_CONTROL, 8'h10, RESP_OKAY);
		w_s <= 4'hF;
		rc(OFS_CONTROL, 8'h00);
		$display("test reset and registers done");
		// Every sink and invert combination
		for (int i = 0; i < 4; i++) begin
			sink_cmd <= i[0];
			wr(OFS_CONTROL, i[1] ? 8'h10 : 8'h00, RESP_OKAY);
			idle(6);
			chk(lvl, i[0] ^ i[1]);
			rc(OFS_CONTROL, {2'b00, i[0] ^ i[1], i[1], 4'h0});
		end
		$display("test polarity done");
		// Every edge enable code, sleep on for half of them
		wr(OFS_IRQ_ENABLE, 8'h10, RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			sleep <= c[1];
			sink_cmd <= 1'b0;
			wr(OFS_CONTROL, 8'(c), RESP_OKAY);
			idle(6);
			wr(OFS_IRQ_FLAG, 8'h10, RESP_OKAY);
			sink_cmd <= 1'b1;
			idle(6);
			chk(irq, c[1]);
			rc(OFS_IRQ_FLAG, {3'b000, c[1], 4'h0});
			rc(OFS_STATUS, {4'h0, c[1], 3'b011});
			wr(OFS_IRQ_FLAG, 8'h10, RESP_OKAY);
			sink_cmd <= 1'b0;
			idle(6);
			rc(OFS_IRQ_FLAG, {3'b000, c[0], 4'h0});
			chk(drive, 1);
		end
		sleep <= 1'b0;
		wr(OFS_IRQ_ENABLE, 8'h00, RESP_OKAY);
		idle(2);
		chk(irq, 0);
		wr(OFS_IRQ_FLAG, 8'h00, RESP_OKAY);
		rc(OFS_IRQ_FLAG, 8'h10);
		wr(OFS_IRQ_FLAG, 8'h10, RESP_OKAY);
		rc(OFS_IRQ_FLAG, 8'h00);
		$display("test edges and interrupt done");
		// Strap set: detector waits for software
		por_dis <= 1'b1;
		do_reset();
		chk(drive, 0);
		chk(dsel, 1);
		rc(OFS_STATUS, 8'h04);
		wr(OFS_CONTROL, 8'h02, RESP_OKAY);
		idle(6);
		wr(OFS_IRQ_FLAG, 8'h10, RESP_OKAY);
		wr(OFS_CONTROL, 8'h12, RESP_OKAY);
		idle(4);
		rc(OFS_IRQ_FLAG, 8'h10);
		wr(OFS_CONTROL, 8'h80, RESP_OKAY);
		idle(3);
		chk(drive, 1);
		chk(dsel, 0);
		wr(OFS_CONTROL, 8'h00, RESP_OKAY);
		idle(3);
		chk(drive, 0);
		$display("test strap set done");
		final_report();
	end
endmodule : zcd_top_tb_top
